// *** inc/pbr_pkg.sv ***
package pbr_pkg;
  // ----------------------------------------------------------------
  // address windows
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam logic [1:0] WIN_FIRST = 2'h0;
  localparam logic [1:0] WIN_SECOND = 2'h1;
  localparam logic [1:0] WIN_THIRD = 2'h2;
  localparam int FIRST_AW = 20;
  localparam int HALF_BIT = 19;
  localparam int SECOND_AW = 16;
  localparam int THIRD_AW = 24;
  localparam int CONSOLE_AW = 16;
  localparam logic [3:0] CONSOLE_SLOT = 4'h8;
  localparam logic [DATA_W-1:0] RSVD_RDATA = 32'h0000_0000;

  // ----------------------------------------------------------------
  // clocking modes and timing channels
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_RSVD = 2'h0;
  localparam logic [1:0] MODE_MASTER = 2'h1;
  localparam logic [1:0] MODE_SLAVE = 2'h2;
  localparam logic [1:0] MODE_GM = 2'h3;
  localparam int CH_N = 5;
  localparam int CH_PPS_OUT = 0;
  localparam int CH_UNUSED = 1;
  localparam int CH_CAL_OUT = 2;
  localparam int CH_PPS_IN = 3;
  localparam int CH_TEN_IN = 4;
  localparam logic [CH_N-1:0] CH_OE_N_RST = 5'h1F;

  // ----------------------------------------------------------------
  // request sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PBR_IDLE = 2'h0,
    PBR_WAIT = 2'h1,
    PBR_DONE = 2'h3
  } pbr_state_t;

  typedef enum logic [2:0] {
    TGT_NONE = 3'h0,
    TGT_CORE = 3'h1,
    TGT_CONSOLE = 3'h2,
    TGT_DMA = 3'h3,
    TGT_DDR = 3'h4
  } pbr_tgt_t;
endpackage

// *** logic/pbr_router.sv ***
`timescale 1ns/1ps
// What this block does
// - The first window spans 1 MB, split into two 512 KB halves by offset bit 19.
// - Lower-half accesses of the first window go to the timing core bus.
// - The upper half of the first window is reserved except the console slot.
// - A 64 KB slot in the upper half reaches the boot console UART.
// - The 64 KB second window reaches the looped-back DMA test engine.
// - The 16 MB third window reaches DDR through the processing system.
// - Reference variant drives pps and cal stamp out, takes pps and 10 MHz in, one channel idle.
// - Low-noise variant re-registers the pps output once more before driving it.
// - Low-noise grand master takes 10 MHz and pps from the coax inputs.
// - Low-noise variant drives 10 MHz and pps on the coax outputs.
// - Mode input decodes 00 reserved, 01 master, 10 slave, 11 grand master.
module pbr_router (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host request
  input wire logic req_valid,
  input wire logic [1:0] req_win,
  input wire logic req_we,
  input wire logic [pbr_pkg::ADDR_W-1:0] req_addr,
  input wire logic [pbr_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  // host completion
  output logic cpl_valid,
  output logic [pbr_pkg::DATA_W-1:0] cpl_rdata,
  // shared target bus
  output logic tgt_we,
  output logic [pbr_pkg::ADDR_W-1:0] tgt_addr,
  output logic [pbr_pkg::DATA_W-1:0] tgt_wdata,
  // timing core target
  output logic core_req,
  input wire logic core_ack,
  input wire logic [pbr_pkg::DATA_W-1:0] core_rdata,
  // boot console target
  output logic console_req,
  input wire logic console_ack,
  input wire logic [pbr_pkg::DATA_W-1:0] console_rdata,
  // dma target
  output logic dma_req,
  input wire logic dma_ack,
  input wire logic [pbr_pkg::DATA_W-1:0] dma_rdata,
  // ddr target
  output logic ddr_req,
  input wire logic ddr_ack,
  input wire logic [pbr_pkg::DATA_W-1:0] ddr_rdata,
  // straps and mode pins
  input wire logic [1:0] mode_pin,
  input wire logic low_noise_pin,
  output logic mode_rsvd,
  output logic mode_master,
  output logic mode_slave,
  output logic mode_gm,
  // timing core signals
  input wire logic core_pps,
  input wire logic core_cal_stamp,
  input wire logic core_ten_mhz,
  output logic ext_pps,
  output logic ext_ten_mhz,
  // reference variant connector channels
  input wire logic [pbr_pkg::CH_N-1:0] ch_in,
  output logic [pbr_pkg::CH_N-1:0] ch_out,
  output logic [pbr_pkg::CH_N-1:0] ch_oe_n,
  // low-noise coax connector
  input wire logic coax_pps_in,
  input wire logic coax_ten_in,
  output logic coax_pps_out,
  output logic coax_ten_out
);
  localparam int NS = 10;
  logic [NS-1:0] sync_in;
  logic [NS-1:0] sync_out;
  logic [1:0] mode_s;
  logic low_noise_s;
  logic [pbr_pkg::CH_N-1:0] ch_s;
  logic coax_pps_s;
  logic coax_ten_s;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign sync_in = {coax_ten_in, coax_pps_in, ch_in, low_noise_pin,
                    mode_pin};
  pbr_sync #(.W(NS)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(sync_in),
    .dout(sync_out)
  );
  assign mode_s = sync_out[1:0];
  assign low_noise_s = sync_out[2];
  assign ch_s = sync_out[7:3];
  assign coax_pps_s = sync_out[8];
  assign coax_ten_s = sync_out[9];

  // ----------------------------------------------------------------
  // address decode and request sequencer
  // ----------------------------------------------------------------
  pbr_pkg::pbr_state_t st_q, st_d;
  pbr_pkg::pbr_tgt_t tgt_q, tgt_d, dec_tgt;
  logic ready_q, ready_d;
  logic cpl_q, cpl_d;
  logic [pbr_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic we_q, we_d;
  logic [pbr_pkg::ADDR_W-1:0] addr_q, addr_d, dec_addr;
  logic [pbr_pkg::DATA_W-1:0] wdata_q, wdata_d;
  logic [3:0] treq_q, treq_d;
  logic tack;
  logic [pbr_pkg::DATA_W-1:0] trdata;

  always_comb begin
    dec_tgt = pbr_pkg::TGT_NONE;
    dec_addr = '0;
    case (req_win)
      pbr_pkg::WIN_FIRST: begin
        if (!req_addr[pbr_pkg::HALF_BIT]) begin
          dec_tgt = pbr_pkg::TGT_CORE;
          dec_addr = {5'h00, req_addr[pbr_pkg::HALF_BIT-1:0]};
        end else if (req_addr[pbr_pkg::FIRST_AW-1:pbr_pkg::CONSOLE_AW]
                     == pbr_pkg::CONSOLE_SLOT) begin
          dec_tgt = pbr_pkg::TGT_CONSOLE;
          dec_addr = {8'h00, req_addr[pbr_pkg::CONSOLE_AW-1:0]};
        end
      end
      pbr_pkg::WIN_SECOND: begin
        dec_tgt = pbr_pkg::TGT_DMA;
        dec_addr = {8'h00, req_addr[pbr_pkg::SECOND_AW-1:0]};
      end
      pbr_pkg::WIN_THIRD: begin
        dec_tgt = pbr_pkg::TGT_DDR;
        dec_addr = req_addr[pbr_pkg::THIRD_AW-1:0];
      end
      default: begin
        dec_tgt = pbr_pkg::TGT_NONE;
      end
    endcase
  end

  always_comb begin
    case (tgt_q)
      pbr_pkg::TGT_CORE: begin
        tack = core_ack;
        trdata = core_rdata;
      end
      pbr_pkg::TGT_CONSOLE: begin
        tack = console_ack;
        trdata = console_rdata;
      end
      pbr_pkg::TGT_DMA: begin
        tack = dma_ack;
        trdata = dma_rdata;
      end
      pbr_pkg::TGT_DDR: begin
        tack = ddr_ack;
        trdata = ddr_rdata;
      end
      default: begin
        tack = 1'b1;
        trdata = pbr_pkg::RSVD_RDATA;
      end
    endcase
  end

  always_comb begin
    st_d = st_q;
    tgt_d = tgt_q;
    ready_d = ready_q;
    cpl_d = 1'b0;
    rdata_d = rdata_q;
    we_d = we_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    treq_d = treq_q;
    case (st_q)
      pbr_pkg::PBR_IDLE: begin
        if (req_valid && ready_q) begin
          st_d = pbr_pkg::PBR_WAIT;
          ready_d = 1'b0;
          tgt_d = dec_tgt;
          we_d = req_we;
          addr_d = dec_addr;
          wdata_d = req_wdata;
          treq_d[0] = (dec_tgt == pbr_pkg::TGT_CORE);
          treq_d[1] = (dec_tgt == pbr_pkg::TGT_CONSOLE);
          treq_d[2] = (dec_tgt == pbr_pkg::TGT_DMA);
          treq_d[3] = (dec_tgt == pbr_pkg::TGT_DDR);
        end
      end
      pbr_pkg::PBR_WAIT: begin
        if (tack) begin
          st_d = pbr_pkg::PBR_DONE;
          treq_d = 4'h0;
          cpl_d = 1'b1;
          rdata_d = we_q ? pbr_pkg::RSVD_RDATA : trdata;
        end
      end
      pbr_pkg::PBR_DONE: begin
        st_d = pbr_pkg::PBR_IDLE;
        ready_d = 1'b1;
      end
      default: begin
        st_d = pbr_pkg::PBR_IDLE;
        ready_d = 1'b1;
        treq_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= pbr_pkg::PBR_IDLE;
      tgt_q <= pbr_pkg::TGT_NONE;
      ready_q <= 1'b1;
      cpl_q <= 1'b0;
      rdata_q <= '0;
      we_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      treq_q <= 4'h0;
    end else begin
      st_q <= st_d;
      tgt_q <= tgt_d;
      ready_q <= ready_d;
      cpl_q <= cpl_d;
      rdata_q <= rdata_d;
      we_q <= we_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      treq_q <= treq_d;
    end
  end

  // ----------------------------------------------------------------
  // mode decode and timing signal routing
  // ----------------------------------------------------------------
  logic [3:0] mode_q, mode_d;
  logic pps_a_q, pps_a_d;
  logic pps_b_q, pps_b_d;
  logic ten_q, ten_d;
  logic ext_pps_q, ext_pps_d;
  logic ext_ten_q, ext_ten_d;
  logic [pbr_pkg::CH_N-1:0] ch_out_q, ch_out_d;
  logic [pbr_pkg::CH_N-1:0] ch_oe_n_q, ch_oe_n_d;

  always_comb begin
    mode_d = 4'h0;
    mode_d[mode_s] = 1'b1;
    pps_a_d = core_pps;
    pps_b_d = low_noise_s ? pps_a_q : 1'b0;
    ten_d = low_noise_s ? core_ten_mhz : 1'b0;
    ch_out_d = '0;
    ch_oe_n_d = pbr_pkg::CH_OE_N_RST;
    if (!low_noise_s) begin
      ch_out_d[pbr_pkg::CH_PPS_OUT] = core_pps;
      ch_out_d[pbr_pkg::CH_CAL_OUT] = core_cal_stamp;
      ch_oe_n_d[pbr_pkg::CH_PPS_OUT] = 1'b0;
      ch_oe_n_d[pbr_pkg::CH_CAL_OUT] = 1'b0;
      ext_pps_d = ch_s[pbr_pkg::CH_PPS_IN];
      ext_ten_d = ch_s[pbr_pkg::CH_TEN_IN];
    end else begin
      ext_pps_d = mode_q[pbr_pkg::MODE_GM] & coax_pps_s;
      ext_ten_d = mode_q[pbr_pkg::MODE_GM] & coax_ten_s;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q <= 4'h0;
      pps_a_q <= 1'b0;
      pps_b_q <= 1'b0;
      ten_q <= 1'b0;
      ext_pps_q <= 1'b0;
      ext_ten_q <= 1'b0;
      ch_out_q <= '0;
      ch_oe_n_q <= pbr_pkg::CH_OE_N_RST;
    end else begin
      mode_q <= mode_d;
      pps_a_q <= pps_a_d;
      pps_b_q <= pps_b_d;
      ten_q <= ten_d;
      ext_pps_q <= ext_pps_d;
      ext_ten_q <= ext_ten_d;
      ch_out_q <= ch_out_d;
      ch_oe_n_q <= ch_oe_n_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign req_ready = ready_q;
  assign cpl_valid = cpl_q;
  assign cpl_rdata = rdata_q;
  assign tgt_we = we_q;
  assign tgt_addr = addr_q;
  assign tgt_wdata = wdata_q;
  assign core_req = treq_q[0];
  assign console_req = treq_q[1];
  assign dma_req = treq_q[2];
  assign ddr_req = treq_q[3];
  assign mode_rsvd = mode_q[pbr_pkg::MODE_RSVD];
  assign mode_master = mode_q[pbr_pkg::MODE_MASTER];
  assign mode_slave = mode_q[pbr_pkg::MODE_SLAVE];
  assign mode_gm = mode_q[pbr_pkg::MODE_GM];
  assign ext_pps = ext_pps_q;
  assign ext_ten_mhz = ext_ten_q;
  assign ch_out = ch_out_q;
  assign ch_oe_n = ch_oe_n_q;
  assign coax_pps_out = pps_b_q;
  assign coax_ten_out = ten_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic take;
  assign take = req_valid && ready_q;

  property p_lower_half;
    @(posedge ref_clk) disable iff (rst)
    take && req_win == pbr_pkg::WIN_FIRST && !req_addr[19]
      |=> core_req && !console_req;
  endproperty
  a_lower_half: assert property (p_lower_half)
    else $error("lower half not routed to core");

  property p_console;
    @(posedge ref_clk) disable iff (rst)
    take && req_win == pbr_pkg::WIN_FIRST && req_addr[19:16] == 4'h8
      |=> console_req && !core_req;
  endproperty
  a_console: assert property (p_console)
    else $error("console slot not routed");

  property p_reserved;
    @(posedge ref_clk) disable iff (rst)
    take && req_win == pbr_pkg::WIN_FIRST && req_addr[19]
      && req_addr[19:16] != 4'h8
      |=> treq_q == 4'h0 ##1 cpl_valid && cpl_rdata == '0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved access did not complete with zero");

  property p_dma;
    @(posedge ref_clk) disable iff (rst)
    take && req_win == pbr_pkg::WIN_SECOND
      |=> dma_req && tgt_addr[23:16] == 8'h00;
  endproperty
  a_dma: assert property (p_dma)
    else $error("second window not routed to dma");

  property p_ddr;
    @(posedge ref_clk) disable iff (rst)
    take && req_win == pbr_pkg::WIN_THIRD
      |=> ddr_req && tgt_addr == $past(req_addr);
  endproperty
  a_ddr: assert property (p_ddr)
    else $error("third window not routed to ddr");

  property p_mode;
    @(posedge ref_clk) disable iff (rst)
    mode_s == 2'h3 |=> mode_gm && !mode_slave && !mode_master;
  endproperty
  a_mode: assert property (p_mode)
    else $error("grand master mode not decoded");

  property p_ref_pps;
    @(posedge ref_clk) disable iff (rst)
    !low_noise_s |=> ch_out[0] == $past(core_pps) && !ch_oe_n[0]
      && ch_oe_n[1];
  endproperty
  a_ref_pps: assert property (p_ref_pps)
    else $error("reference pps channel wrong");

  property p_ln_pps;
    @(posedge ref_clk) disable iff (rst)
    low_noise_s ##1 low_noise_s |=> coax_pps_out == $past(core_pps, 2);
  endproperty
  a_ln_pps: assert property (p_ln_pps)
    else $error("low-noise pps not re-registered");

  property p_gm_in;
    @(posedge ref_clk) disable iff (rst)
    low_noise_s && mode_gm |=> ext_pps == $past(coax_pps_s)
      && ext_ten_mhz == $past(coax_ten_s);
  endproperty
  a_gm_in: assert property (p_gm_in)
    else $error("grand master coax pps not taken");

  property p_ten_out;
    @(posedge ref_clk) disable iff (rst)
    low_noise_s |=> coax_ten_out == $past(core_ten_mhz);
  endproperty
  a_ten_out: assert property (p_ten_out)
    else $error("coax 10 MHz output wrong");
endmodule

// *** logic/pbr_sync.sv ***
`timescale 1ns/1ps
module pbr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // async in, filtered out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // ----------------------------------------------------------------
  // per bit: accept once second and third stage agree
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule

// *** testbench/pbr_router_tb_top.sv ***
`timescale 1ns/1ps
module pbr_router_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic [1:0] req_win = 2'h0;
  logic req_we = 1'b0;
  logic [23:0] req_addr = 24'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0] dly_r = 4'h0;
  logic [1:0] mode_pin = 2'h2;
  logic low_noise_pin = 1'b0;
  logic core_pps = 1'b0;
  logic core_cal_stamp = 1'b0;
  logic core_ten_mhz = 1'b0;
  logic [4:0] ch_in = 5'h00;
  logic coax_pps_in = 1'b0;
  logic coax_ten_in = 1'b0;
  logic req_ready, cpl_valid, tgt_we;
  logic [31:0] cpl_rdata, tgt_wdata;
  logic [23:0] tgt_addr;
  logic core_req, console_req, dma_req, ddr_req;
  logic core_ack, console_ack, dma_ack, ddr_ack;
  logic [31:0] core_rdata, console_rdata, dma_rdata, ddr_rdata;
  logic mode_rsvd, mode_master, mode_slave, mode_gm;
  logic ext_pps, ext_ten_mhz, coax_pps_out, coax_ten_out;
  logic [4:0] ch_out, ch_oe_n;
  logic [3:0] reqs;
  int fail_count = 0;
  int checks = 0;

  assign reqs = {ddr_req, dma_req, console_req, core_req};
  always #50 ref_clk = ~ref_clk;

  pbr_router DUT (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .req_win(req_win), .req_we(req_we), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .cpl_valid(cpl_valid),
    .cpl_rdata(cpl_rdata), .tgt_we(tgt_we), .tgt_addr(tgt_addr),
    .tgt_wdata(tgt_wdata), .core_req(core_req), .core_ack(core_ack),
    .core_rdata(core_rdata), .console_req(console_req),
    .console_ack(console_ack), .console_rdata(console_rdata),
    .dma_req(dma_req), .dma_ack(dma_ack), .dma_rdata(dma_rdata),
    .ddr_req(ddr_req), .ddr_ack(ddr_ack), .ddr_rdata(ddr_rdata),
    .mode_pin(mode_pin), .low_noise_pin(low_noise_pin),
    .mode_rsvd(mode_rsvd), .mode_master(mode_master),
    .mode_slave(mode_slave), .mode_gm(mode_gm), .core_pps(core_pps),
    .core_cal_stamp(core_cal_stamp), .core_ten_mhz(core_ten_mhz),
    .ext_pps(ext_pps), .ext_ten_mhz(ext_ten_mhz), .ch_in(ch_in),
    .ch_out(ch_out), .ch_oe_n(ch_oe_n), .coax_pps_in(coax_pps_in),
    .coax_ten_in(coax_ten_in), .coax_pps_out(coax_pps_out),
    .coax_ten_out(coax_ten_out));

  pbr_tgt_model #(.TAG(8'hC1)) u_core (.ref_clk(ref_clk), .rst(rst),
    .req(core_req), .addr(tgt_addr), .dly(dly_r), .ack(core_ack),
    .rdata(core_rdata));
  pbr_tgt_model #(.TAG(8'hC2)) u_console (.ref_clk(ref_clk), .rst(rst),
    .req(console_req), .addr(tgt_addr), .dly(dly_r), .ack(console_ack),
    .rdata(console_rdata));
  pbr_tgt_model #(.TAG(8'hC3)) u_dma (.ref_clk(ref_clk), .rst(rst),
    .req(dma_req), .addr(tgt_addr), .dly(dly_r), .ack(dma_ack),
    .rdata(dma_rdata));
  pbr_tgt_model #(.TAG(8'hC4)) u_ddr (.ref_clk(ref_clk), .rst(rst),
    .req(ddr_req), .addr(tgt_addr), .dly(dly_r), .ack(ddr_ack),
    .rdata(ddr_rdata));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // one host access; ev is {ddr,dma,console,core}
  task automatic acc(input logic [1:0] win, input logic we,
      input logic [23:0] addr, input logic [31:0] wd, input logic [3:0] dl,
      input logic [3:0] ev, input logic [23:0] ea, input logic [31:0] er);
    logic [3:0] seen;
    logic [23:0] ta;
    logic tw;
    logic [31:0] td;
    int n;
    seen = 4'h0;
    ta = 24'h0;
    tw = 1'b0;
    td = 32'h0;
    n = 0;
    @(posedge ref_clk);
    dly_r <= dl;
    req_valid <= 1'b1;
    req_win <= win;
    req_we <= we;
    req_addr <= addr;
    req_wdata <= wd;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      if (|reqs) begin
        seen |= reqs;
        ta = tgt_addr;
        tw = tgt_we;
        td = tgt_wdata;
      end
    end while (cpl_valid !== 1'b1 && n < 40);
    chk("cpl_valid", cpl_valid, 32'h1);
    chk("target", seen, ev);
    if (ev != 4'h0) begin
      chk("tgt_addr", ta, ea);
      chk("tgt_we", tw, we);
      if (we) chk("tgt_wdata", td, wd);
    end
    chk("cpl_rdata", cpl_rdata, er);
    @(negedge ref_clk);
    chk("cpl_pulse", cpl_valid, 32'h0);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_windows;
    acc(2'h0, 1'b0, 24'h000000, 32'h0, 4'h0, 4'h1, 24'h000000,
        32'hC100_0000);
    acc(2'h0, 1'b1, 24'h07FFFC, 32'h1234_5678, 4'h3, 4'h1, 24'h07FFFC,
        32'h0);
    acc(2'h0, 1'b0, 24'h080004, 32'h0, 4'h2, 4'h2, 24'h000004,
        32'hC200_0004);
    acc(2'h0, 1'b0, 24'h090000, 32'h0, 4'h0, 4'h0, 24'h0, 32'h0);
    acc(2'h0, 1'b1, 24'h08FFFC, 32'h5A5A_0001, 4'h0, 4'h2, 24'h00FFFC,
        32'h0);
    acc(2'h0, 1'b1, 24'h0FFFFC, 32'hFFFF_FFFF, 4'h0, 4'h0, 24'h0,
        32'h0);
    acc(2'h1, 1'b0, 24'h00FFFC, 32'h0, 4'h5, 4'h4, 24'h00FFFC,
        32'hC300_FFFC);
    acc(2'h2, 1'b1, 24'hFFFFFC, 32'hCAFE_F00D, 4'h1, 4'h8, 24'hFFFFFC,
        32'h0);
    acc(2'h2, 1'b0, 24'h000010, 32'h0, 4'h0, 4'h8, 24'h000010,
        32'hC400_0010);
    acc(2'h3, 1'b0, 24'h000000, 32'h0, 4'h0, 4'h0, 24'h0, 32'h0);
    $display("windows test done");
  endtask

  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      mode_pin <= 2'(i);
      cyc(8);
      chk("mode", {mode_gm, mode_slave, mode_master, mode_rsvd},
          32'(4'h1 << i));
    end
    $display("mode test done");
  endtask

  task automatic t_ref;
    @(posedge ref_clk);
    low_noise_pin <= 1'b0;
    ch_in <= 5'h08;
    core_pps <= 1'b1;
    core_cal_stamp <= 1'b0;
    cyc(8);
    chk("ch_oe_n", ch_oe_n, 32'h1A);
    chk("ext_pps", {ext_ten_mhz, ext_pps}, 32'h1);
    @(posedge ref_clk);
    core_pps <= 1'b0;
    core_cal_stamp <= 1'b1;
    ch_in <= 5'h10;
    @(negedge ref_clk);
    chk("ch_out", {ch_out[2], ch_out[0]}, 32'h1);
    @(negedge ref_clk);
    chk("ch_out", {ch_out[2], ch_out[0]}, 32'h2);
    cyc(8);
    chk("ext_ten", {ext_ten_mhz, ext_pps}, 32'h2);
    $display("reference variant test done");
  endtask

  task automatic t_low_noise;
    @(posedge ref_clk);
    low_noise_pin <= 1'b1;
    mode_pin <= 2'h3;
    coax_pps_in <= 1'b1;
    coax_ten_in <= 1'b0;
    core_pps <= 1'b0;
    core_ten_mhz <= 1'b1;
    cyc(8);
    chk("ch_oe_n", ch_oe_n, 32'h1F);
    chk("ext_gm", {ext_ten_mhz, ext_pps}, 32'h1);
    @(posedge ref_clk);
    core_pps <= 1'b1;
    core_ten_mhz <= 1'b0;
    @(negedge ref_clk);
    chk("coax_out", {coax_ten_out, coax_pps_out}, 32'h2);
    @(negedge ref_clk);
    chk("coax_out", {coax_ten_out, coax_pps_out}, 32'h0);
    @(negedge ref_clk);
    chk("coax_out", {coax_ten_out, coax_pps_out}, 32'h1);
    @(posedge ref_clk);
    coax_ten_in <= 1'b1;
    cyc(8);
    chk("ext_gm_ten", {ext_ten_mhz, ext_pps}, 32'h3);
    @(posedge ref_clk);
    mode_pin <= 2'h2;
    cyc(8);
    chk("ext_slave", {ext_ten_mhz, ext_pps}, 32'h0);
    $display("low-noise variant test done");
  endtask

  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("rst_ready", req_ready, 32'h1);
    chk("rst_oe_n", ch_oe_n, 32'h1F);
    chk("rst_cpl", cpl_valid, 32'h0);
    @(posedge ref_clk);
    rst <= 1'b0;
    t_windows();
    t_modes();
    t_ref();
    t_low_noise();
    report_and_stop();
  end

  initial begin
    #3000000;
    fail_count++;
    report_and_stop();
  end
endmodule

// *** testbench/pbr_tgt_model.sv ***
`timescale 1ns/1ps
module pbr_tgt_model #(
  parameter logic [7:0] TAG = 8'h00
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request side
  input wire logic req,
  input wire logic [pbr_pkg::ADDR_W-1:0] addr,
  input wire logic [3:0] dly,
  // answer side
  output logic ack,
  output logic [pbr_pkg::DATA_W-1:0] rdata
);
  logic [3:0] cnt_q;

  // ------------------------------------------------------------------
  // target answer, dly wait cycles before ack
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      ack <= 1'b0;
      rdata <= 32'hA5A5_5A5A;
    end else if (req && !ack && cnt_q == dly) begin
      ack <= 1'b1;
      cnt_q <= 4'h0;
      rdata <= {TAG, addr};
    end else begin
      ack <= 1'b0;
      // stale data toggles each cycle, so the last valid word comes back every second cycle
      rdata <= ~rdata;
      if (req && !ack) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule
